// *** design/beim_cfg.svh ***
// timing counts, bit positions and reset values of the boot eeprom master
`ifndef BEIM_CFG_SVH
`define BEIM_CFG_SVH

// ----------------------------------------------------------------------
// clock and bit timing
// ----------------------------------------------------------------------
`define BEIM_CLK_PERIOD_NS 4
// quarter of one serial bit period, 100 kbit/s and 400 kbit/s
`define BEIM_QTR_100K_NS 2500
`define BEIM_QTR_400K_NS 625
// least times, so round up to whole cycles
`define BEIM_QTR_100K_CYC ((`BEIM_QTR_100K_NS + `BEIM_CLK_PERIOD_NS - 1) / `BEIM_CLK_PERIOD_NS)
`define BEIM_QTR_400K_CYC ((`BEIM_QTR_400K_NS + `BEIM_CLK_PERIOD_NS - 1) / `BEIM_CLK_PERIOD_NS)
`define BEIM_DIV_W 10

// ----------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------
`define BEIM_ACK_IDX 4'h8
`define BEIM_RW_BIT 0
`define BEIM_MSB_BIT 7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BEIM_RST_PULLUP 1'b1
`define BEIM_RST_TX_EMPTY 1'b1
`define BEIM_RST_BYTE 8'h00

`endif

// *** design/beim_pkg.sv ***
// types shared by the boot eeprom master
package beim_pkg;

  // ----------------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_BIT   = 5'h04,
    ST_HOLD  = 5'h08,
    ST_STOP  = 5'h10
  } beim_state_e;

  typedef logic [1:0] beim_phase_t;

  // ----------------------------------------------------------------------
  // status flags seen by firmware
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic tx_empty;
    logic rx_full;
    logic err;
  } beim_stat_s;

  // open-drain drive request for both lines; 1 releases the line
  typedef struct packed {
    logic scl_rel;
    logic sda_rel;
  } beim_lines_s;

endpackage

// *** design/beim_qtick.sv ***
// quarter bit period tick generator for the boot eeprom master
`timescale 1ns/1ns
`default_nettype none
`include "beim_cfg.svh"

module beim_qtick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast,
  output logic tick
);

  logic [`BEIM_DIV_W-1:0] cnt_q;
  logic [`BEIM_DIV_W-1:0] cnt_d;
  wire logic [`BEIM_DIV_W-1:0] limit;
  wire logic wrap;

  assign limit = fast ? `BEIM_DIV_W'(`BEIM_QTR_400K_CYC - 1)
                      : `BEIM_DIV_W'(`BEIM_QTR_100K_CYC - 1);
  assign wrap = (cnt_q == limit);
  // a stalled run restarts the quarter so phases stay roughly equal
  assign cnt_d = (!run || wrap) ? '0 : cnt_q + `BEIM_DIV_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= run & wrap;
    end
  end

endmodule
`default_nettype wire

// *** design/beim_master.sv ***
// boot eeprom two-wire master: sequencer, shifter, flags and pins
//
// How it works
// R1: master only, no arbitration; assumes it is the sole bus master.
// R2: bit rate selectable between 100 kbit/s and 400 kbit/s.
// R3: memory address sent after device address, 8 or 16 bits.
// R4: single and sequential multi-byte reads and writes supported.
// R5: clock line open-drain only: pulled low or released, never driven high.
// R6: data line bidirectional open-drain, wire-ORed with slave outputs.
// R7: weak pull-ups on both lines enabled after reset; lines idle high.
// R8: master starts every transfer and clocks all data and ack bits.
// R9: bytes move eight bits, most significant first, one per clock.
// R10: receiver returns acknowledge in a ninth clock period.
// R11: every transaction opens with start, closes with stop.
// R12: data stable while clock high; changes only while clock low.
// R13: start is data falling while clock high.
// R14: stop is data rising while clock high.
// R15: receiver acks with steady low; master leaves final read byte unacked.
// R16: transmitter releases data line during the acknowledge clock.
// R17: serves small (11-bit) and large (16-bit address) eeproms alike.
// R18: slave address register content is sent as the address byte.
// R19: memory cell address bytes come from the transmit data register.
// R20: provides the read path from eeprom into code ram.
// R21: stop request set: stop after current byte; clear: no stop.
// R22: clock period divided from system clock, high and low roughly equal.
// R23: missing expected ack sets error flag and ends the transfer.
`timescale 1ns/1ns
`default_nettype none
`include "beim_cfg.svh"

module beim_master (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // serial clock pin, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  // serial data pin, open drain
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  // weak pull-up enable for both pins
  output logic PULLUP_EN,
  // slave address register write; bit 0 selects read
  input wire logic [7:0] SLAVE_ADDRESS_IN,
  input wire logic SLAVE_ADDRESS_WR,
  // transmit data register write
  input wire logic [7:0] TRANSMIT_DATA_IN,
  input wire logic TRANSMIT_DATA_WR,
  // receive data register and its read strobe
  output logic [7:0] RECEIVE_DATA_OUT,
  input wire logic RECEIVE_DATA_RD,
  // control bits
  input wire logic STOP_REQ,
  input wire logic SPEED_400K,
  input wire logic ERR_CLR,
  // status bits
  output logic TRANSMIT_EMPTY_FLAG,
  output logic RECEIVE_FULL,
  output logic ERR,
  output logic BUSY
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic scl_s1_q;
  logic scl_s2_q;
  logic sda_s1_q;
  logic sda_s2_q;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= SCL_I;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= SDA_I;
      sda_s2_q <= sda_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  beim_pkg::beim_state_e state_q;
  beim_pkg::beim_state_e state_d;
  beim_pkg::beim_phase_t phase_q;
  beim_pkg::beim_lines_s lines_q;
  beim_pkg::beim_lines_s lines_d;
  beim_pkg::beim_stat_s stat_q;
  beim_pkg::beim_stat_s stat_d;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] slave_address_reg_q;
  logic [7:0] transmit_data_reg_q;
  logic [7:0] receive_data_reg_q;
  logic addr_pend_q;
  logic addr_byte_q;
  logic read_mode_q;
  logic rd_byte_q;
  logic last_q;
  logic nack_q;
  logic pullup_q;
  logic low_q;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire logic tick;
  wire logic active;
  wire logic stretch;
  wire logic ack_slot;
  wire logic bit_end;
  wire logic byte_end;
  wire logic seq_end;
  wire logic hold_rd;
  wire logic hold_wr;
  wire logic hold_stop;
  wire logic take_addr;
  wire logic load_tx;
  wire logic got_byte;
  wire logic nack_err;
  wire logic tx_bit;
  wire logic sample;

  assign active = (state_q != beim_pkg::ST_IDLE)
                & (state_q != beim_pkg::ST_HOLD);
  // a slave holding the clock low restarts the quarter count
  assign stretch = lines_q.scl_rel & ~scl_s2_q;
  assign ack_slot = (bitcnt_q == `BEIM_ACK_IDX);
  assign sample = tick & (state_q == beim_pkg::ST_BIT)
                & (phase_q == 2'h2);
  assign bit_end = tick & (state_q == beim_pkg::ST_BIT)
                 & (phase_q == 2'h3);
  assign byte_end = bit_end & ack_slot;
  assign seq_end = tick & (phase_q == 2'h3);
  assign take_addr = (state_q == beim_pkg::ST_IDLE) & addr_pend_q
                   | (state_q == beim_pkg::ST_HOLD) & addr_pend_q;
  // next byte choices while parked with the clock held low
  assign hold_rd = (state_q == beim_pkg::ST_HOLD) & ~addr_pend_q
                 & read_mode_q & ~stat_q.rx_full;
  assign hold_wr = (state_q == beim_pkg::ST_HOLD) & ~addr_pend_q
                 & ~read_mode_q & ~stat_q.tx_empty;
  assign hold_stop = (state_q == beim_pkg::ST_HOLD) & ~addr_pend_q
                   & ~read_mode_q & stat_q.tx_empty & STOP_REQ;
  assign load_tx = hold_wr;
  assign got_byte = byte_end & rd_byte_q;
  assign nack_err = byte_end & ~rd_byte_q & nack_q;
  assign tx_bit = shift_q[`BEIM_MSB_BIT];

  beim_qtick u_qtick (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .run(active & ~stretch),
    .fast(SPEED_400K),
    .tick(tick)
  ); // [R2] [R22]

  // entering a sequence restarts the phase count; the lines decode the
  // next phase so a state change never lets a stray clock pulse out
  wire logic [1:0] phase_d;
  assign phase_d = (state_d != state_q) ? 2'h0
                 : tick ? phase_q + 2'h1 : phase_q;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      beim_pkg::ST_IDLE: begin
        if (take_addr) begin
          state_d = beim_pkg::ST_START; // [R8] [R11]
        end
      end
      beim_pkg::ST_START: begin
        if (seq_end) begin
          state_d = beim_pkg::ST_BIT;
        end
      end
      beim_pkg::ST_BIT: begin
        if (byte_end) begin
          if (nack_err || last_q) begin
            state_d = beim_pkg::ST_STOP; // [R21] [R23]
          end else begin
            state_d = beim_pkg::ST_HOLD; // [R4]
          end
        end
      end
      beim_pkg::ST_HOLD: begin
        if (take_addr) begin
          state_d = beim_pkg::ST_START;
        end else if (hold_rd || hold_wr) begin
          state_d = beim_pkg::ST_BIT; // [R4]
        end else if (hold_stop) begin
          state_d = beim_pkg::ST_STOP; // [R11]
        end
      end
      beim_pkg::ST_STOP: begin
        if (seq_end) begin
          state_d = beim_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = beim_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // line drive per state and phase
  // ----------------------------------------------------------------------
  // the clock is never driven high, only released to the pull-up
  always_comb begin
    lines_d = lines_q;
    case (state_d)
      beim_pkg::ST_IDLE: begin
        lines_d = '{scl_rel: 1'b1, sda_rel: 1'b1}; // [R7]
      end
      beim_pkg::ST_START: begin
        // ph0 clock low, ph1 both released, ph2 data falls, ph3 clock low
        lines_d.scl_rel = (phase_d == 2'h1) | (phase_d == 2'h2);
        lines_d.sda_rel = phase_d[1] ? 1'b0 : 1'b1; // [R13]
      end
      beim_pkg::ST_BIT: begin
        // data is set in ph0 under a low clock and kept through ph3
        lines_d.scl_rel = phase_d[1]; // [R5] [R12]
        if (ack_slot) begin
          lines_d.sda_rel = rd_byte_q ? last_q : 1'b1; // [R15] [R16]
        end else begin
          lines_d.sda_rel = rd_byte_q ? 1'b1 : tx_bit; // [R6] [R9]
        end
      end
      beim_pkg::ST_HOLD: begin
        lines_d.scl_rel = 1'b0;
      end
      beim_pkg::ST_STOP: begin
        // ph0 keeps data, ph1 data low, ph2 clock up, ph3 data rises
        lines_d.scl_rel = phase_d[1];
        lines_d.sda_rel = (phase_d == 2'h0) ? lines_q.sda_rel
                        : (phase_d == 2'h3); // [R14]
      end
      default: begin
        lines_d = '{scl_rel: 1'b1, sda_rel: 1'b1};
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= beim_pkg::ST_IDLE;
      phase_q <= 2'h0;
      lines_q <= '{scl_rel: 1'b1, sda_rel: 1'b1};
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      lines_q <= lines_d;
    end
  end

  // ----------------------------------------------------------------------
  // byte shifter
  // ----------------------------------------------------------------------
  wire logic start_done;
  wire logic [3:0] bitcnt_d;
  wire logic [7:0] shift_d;

  assign start_done = seq_end & (state_q == beim_pkg::ST_START);
  assign bitcnt_d = (start_done || load_tx || hold_rd) ? 4'h0
                  : (bit_end && !ack_slot) ? bitcnt_q + 4'h1
                  : bitcnt_q;
  // device address first, memory address and data after it
  assign shift_d = start_done ? slave_address_reg_q // [R18]
                 : load_tx ? transmit_data_reg_q // [R19] [R3] [R17]
                 : (sample && rd_byte_q && !ack_slot)
                   ? {shift_q[6:0], sda_s2_q}
                 : (bit_end && !rd_byte_q && !ack_slot)
                   ? {shift_q[6:0], 1'b0} // [R9]
                 : shift_q;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bitcnt_q <= 4'h0;
      shift_q <= `BEIM_RST_BYTE;
    end else begin
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------------------------------------
  // per byte attributes
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_byte_q <= 1'b0;
      rd_byte_q <= 1'b0;
      last_q <= 1'b0;
      read_mode_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      if (start_done) begin
        addr_byte_q <= 1'b1;
        rd_byte_q <= 1'b0;
        last_q <= 1'b0;
      end else if (load_tx || hold_rd) begin
        addr_byte_q <= 1'b0;
        rd_byte_q <= hold_rd;
        last_q <= STOP_REQ; // [R21]
      end
      if (byte_end && addr_byte_q) begin
        read_mode_q <= slave_address_reg_q[`BEIM_RW_BIT];
      end
      if (sample && ack_slot) begin
        nack_q <= sda_s2_q; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------------
  // firmware registers and flags
  // ----------------------------------------------------------------------
  // hardware set wins over a clear in the same cycle for rx_full and err; for tx_empty a transmit data write wins over load_tx
  assign stat_d.busy = (state_d != beim_pkg::ST_IDLE);
  assign stat_d.tx_empty = TRANSMIT_DATA_WR ? 1'b0
                         : (load_tx | stat_q.tx_empty);
  assign stat_d.rx_full = got_byte | (stat_q.rx_full & ~RECEIVE_DATA_RD);
  assign stat_d.err = nack_err | (stat_q.err & ~ERR_CLR); // [R23]

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      slave_address_reg_q <= `BEIM_RST_BYTE;
      transmit_data_reg_q <= `BEIM_RST_BYTE;
      receive_data_reg_q <= `BEIM_RST_BYTE;
      addr_pend_q <= 1'b0;
      stat_q <= '{busy: 1'b0, tx_empty: `BEIM_RST_TX_EMPTY,
                  rx_full: 1'b0, err: 1'b0};
    end else begin
      if (SLAVE_ADDRESS_WR) begin
        slave_address_reg_q <= SLAVE_ADDRESS_IN;
      end
      if (TRANSMIT_DATA_WR) begin
        transmit_data_reg_q <= TRANSMIT_DATA_IN;
      end
      if (got_byte) begin
        receive_data_reg_q <= shift_q; // [R20]
      end
      // a write of the address always begins a new transaction
      addr_pend_q <= SLAVE_ADDRESS_WR | (addr_pend_q & ~take_addr); // [R1]
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // no arbitration: a released line is never read back for loss
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pullup_q <= `BEIM_RST_PULLUP;
      low_q <= 1'b0;
    end else begin
      pullup_q <= `BEIM_RST_PULLUP; // [R7]
      low_q <= 1'b0; // [R5] [R6]
    end
  end

  assign SCL_O = low_q;
  assign SDA_O = low_q;
  assign SCL_OE_N = lines_q.scl_rel;
  assign SDA_OE_N = lines_q.sda_rel;
  assign PULLUP_EN = pullup_q;
  assign RECEIVE_DATA_OUT = receive_data_reg_q;
  assign TRANSMIT_EMPTY_FLAG = stat_q.tx_empty;
  assign RECEIVE_FULL = stat_q.rx_full;
  assign ERR = stat_q.err;
  assign BUSY = stat_q.busy;

endmodule
`default_nettype wire

// *** sim/beim_master_props.sv ***
// checker for the boot eeprom master pins and flags
`timescale 1ns/1ns
`default_nettype none
module beim_master_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // pins
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_N,
  input wire logic SDA_O,
  input wire logic SDA_OE_N,
  // control and status
  input wire logic [7:0] SLAVE_ADDRESS_IN,
  input wire logic SLAVE_ADDRESS_WR,
  input wire logic SPEED_400K,
  input wire logic ERR,
  input wire logic BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // ------
  // bit position tracker
  // ------
  logic scl_p_q, sda_p_q, hdr_q;
  logic [3:0] bit_q;
  logic [11:0] hi_q;
  logic [7:0] adr_q;
  wire start_w = SCL_OE_N && sda_p_q && !SDA_OE_N;
  wire rise_w = SCL_OE_N && !scl_p_q;
  wire stop_w = SCL_OE_N && !sda_p_q && SDA_OE_N && BUSY;
  // cycles busy since the stop edge and since an error rose
  logic err_p_q;
  logic [10:0] stp_q;
  logic [11:0] erc_q;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      hdr_q <= 1'b0;
      bit_q <= 4'hF;
      hi_q <= 12'h000;
      err_p_q <= 1'b0;
      stp_q <= 11'h000;
      erc_q <= 12'h000;
    end else begin
      scl_p_q <= SCL_OE_N;
      sda_p_q <= SDA_OE_N;
      err_p_q <= ERR;
      stp_q <= !BUSY ? 11'h000 : stop_w ? 11'h001
             : (stp_q != 11'h000 && !(&stp_q)) ? stp_q + 11'h001 : stp_q;
      erc_q <= !BUSY ? 12'h000 : (ERR && !err_p_q) ? 12'h001
             : (erc_q != 12'h000 && !(&erc_q)) ? erc_q + 12'h001 : erc_q;
      // saturates so a long idle high cannot wrap
      hi_q <= !SCL_OE_N ? 12'h000 : (&hi_q ? hi_q : hi_q + 12'h001);
      if (start_w) begin
        bit_q <= 4'hF;
        hdr_q <= 1'b1;
      end else if (rise_w) begin
        bit_q <= (bit_q == 4'h8 || bit_q == 4'hF) ? 4'h0 : bit_q + 4'h1;
        if (bit_q == 4'h8) hdr_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (SLAVE_ADDRESS_WR) adr_q <= SLAVE_ADDRESS_IN;
  end
  a_scl_od_only: assert property (SCL_O == 1'b0)
    else $error("scl driven high");
  a_sda_od_only: assert property (SDA_O == 1'b0)
    else $error("sda driven high");
  a_start_scl_high: assert property (start_w |-> SCL_I ##1 SCL_OE_N [*8])
    else $error("start not under high scl");
  a_stop_then_idle: assert property (stp_q <= 11'h578)
    else $error("stop not followed by idle");
  a_sda_moves_low: assert property ($changed(SDA_OE_N) && SCL_OE_N
    |-> $past(SCL_OE_N, 8))
    else $error("sda moved near scl edge");
  a_scl_high_time: assert property ($fell(SCL_OE_N) && $past(BUSY)
    |-> SPEED_400K ? hi_q inside {[12'h136:12'h14F]}
    : hi_q inside {[12'h4DD:12'h4FB]})
    else $error("scl high time off");
  a_addr_msb_first: assert property (SCL_OE_N && scl_p_q && hdr_q
    && bit_q < 4'h8 |-> SDA_OE_N == adr_q[3'h7 - bit_q[2:0]])
    else $error("address bit wrong");
  a_ack_released: assert property (SCL_OE_N && scl_p_q && hdr_q
    && bit_q == 4'h8 |-> SDA_OE_N)
    else $error("sda held in ack clock");
  a_busy_start: assert property (SLAVE_ADDRESS_WR && !BUSY
    |-> ##2 BUSY && !SCL_OE_N)
    else $error("transfer did not start");
  a_err_ends: assert property (erc_q <= 12'hFA0)
    else $error("transfer kept on after error");
endmodule
bind beim_master beim_master_props beim_master_props_i (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_N(SCL_OE_N), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
  .SLAVE_ADDRESS_IN(SLAVE_ADDRESS_IN), .SLAVE_ADDRESS_WR(SLAVE_ADDRESS_WR),
  .SPEED_400K(SPEED_400K), .ERR(ERR), .BUSY(BUSY)
);
`default_nettype wire

// *** sim/beim_eeprom_model.sv ***
// behavioural serial eeprom answering the boot master
`timescale 1ns/1ns
`default_nettype none
module beim_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic nack_seen
);
  logic [7:0] mem [0:255];
  logic [7:0] sh_q, ptr_q, out_q;
  logic act_q, rd_q, hdr_q, first_q;
  int bit_n;
  initial begin
    sda_pull = 1'b0;
    nack_seen = 1'b0;
    act_q = 1'b0;
    rd_q = 1'b0;
    bit_n = -1;
  end
  always @(negedge sda) begin
    if (scl) begin
      act_q = 1'b1;
      hdr_q = 1'b1;
      bit_n = -1;
    end
  end
  always @(posedge sda) begin
    if (scl) act_q = 1'b0;
  end
  always @(posedge scl) begin
    if (act_q && bit_n >= 0) begin
      if (bit_n < 8) sh_q = {sh_q[6:0], sda};
      else if (rd_q && !hdr_q && sda) begin
        nack_seen = 1'b1;
        act_q = 1'b0;
      end
    end
  end
  // drive only after scl falls, so data never moves under high scl
  always @(negedge scl) begin
    if (act_q) begin
      if (bit_n == 7) begin
        if (hdr_q) begin
          rd_q = sh_q[0];
          act_q = (sh_q[7:1] == DEV_ADDR);
          sda_pull = act_q;
          first_q = 1'b1;
        end else if (!rd_q) begin
          if (first_q) ptr_q = sh_q;
          else begin
            mem[ptr_q] = sh_q;
            ptr_q = ptr_q + 8'h01;
          end
          first_q = 1'b0;
          sda_pull = 1'b1;
        end else sda_pull = 1'b0;
        hdr_q = 1'b0;
        bit_n = 8;
      end else if (bit_n == 8) begin
        bit_n = 0;
        out_q = mem[ptr_q];
        sda_pull = rd_q && !out_q[7];
        if (rd_q) ptr_q = ptr_q + 8'h01;
      end else begin
        bit_n = bit_n + 1;
        sda_pull = rd_q && !hdr_q && !out_q[7 - bit_n];
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the boot eeprom master
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] val = 8'h00;
  logic sa_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0, err_clr = 1'b0;
  logic stop_req = 1'b0, speed = 1'b1;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, pull_en;
  logic tx_empty, rx_full, err, busy, sda_pull, nack_seen;
  logic [7:0] rx_data;
  int n_mismatch = 0;
  int n_checks = 0;
  // released lines rise through the pull-ups
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n && !sda_pull;
  always #2 ref_clk = ~ref_clk;
  beim_master beim_master_i (
    .REF_CLK(ref_clk), .RSTN(rstn),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .PULLUP_EN(pull_en),
    .SLAVE_ADDRESS_IN(val), .SLAVE_ADDRESS_WR(sa_wr),
    .TRANSMIT_DATA_IN(val), .TRANSMIT_DATA_WR(tx_wr),
    .RECEIVE_DATA_OUT(rx_data), .RECEIVE_DATA_RD(rx_rd),
    .STOP_REQ(stop_req), .SPEED_400K(speed), .ERR_CLR(err_clr),
    .TRANSMIT_EMPTY_FLAG(tx_empty), .RECEIVE_FULL(rx_full),
    .ERR(err), .BUSY(busy)
  );
  beim_eeprom_model beim_eeprom_model_i (
    .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .nack_seen(nack_seen)
  );
  // ------
  // shared tasks
  // ------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes, then one spare edge so the flags have landed
  task automatic put(input logic a, input logic t, input logic r,
                     input logic c, input logic s, input logic [7:0] v);
    @(posedge ref_clk);
    sa_wr <= a;
    tx_wr <= t;
    rx_rd <= r;
    err_clr <= c;
    stop_req <= s;
    val <= v;
    @(posedge ref_clk);
    sa_wr <= 1'b0;
    tx_wr <= 1'b0;
    rx_rd <= 1'b0;
    err_clr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // 0 idle, 1 tx empty, 2 rx full; bound covers a 100k byte
  task automatic wait_on(input int kind);
    int n;
    n = 0;
    while (n < 40000 && !(kind == 0 ? busy === 1'b0 :
           kind == 1 ? tx_empty === 1'b1 : rx_full === 1'b1)) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 40000) chk("wait", 8'h01, 8'h00);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    #1;
    chk("reset pins", 8'hF0, {pull_en, scl_oe_n, sda_oe_n, tx_empty,
        busy, err, rx_full, 1'b0});
    $display("reset test done");
  endtask
  task automatic t_write;
    put(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hA0);
    put(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h12);
    chk("tx empty", 8'h00, tx_empty);
    wait_on(1);
    put(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h5A);
    wait_on(1);
    put(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'hA5);
    wait_on(0);
    chk("write err", 8'h00, err);
    chk("cell 12", 8'h5A, beim_eeprom_model_i.mem[8'h12]);
    chk("cell 13", 8'hA5, beim_eeprom_model_i.mem[8'h13]);
    $display("write test done");
  endtask
  task automatic t_read;
    put(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hA0);
    put(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h12);
    wait_on(1);
    put(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hA1);
    wait_on(2);
    chk("read 1", 8'h5A, rx_data);
    put(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    chk("rx cleared", 8'h00, rx_full);
    wait_on(2);
    chk("read 2", 8'hA5, rx_data);
    put(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    wait_on(0);
    chk("last nack", 8'h01, nack_seen);
    $display("read test done");
  endtask
  task automatic t_nack;
    @(posedge ref_clk);
    speed <= 1'b0;
    put(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hB0);
    chk("busy", 8'h01, busy);
    wait_on(0);
    chk("nack err", 8'h01, err);
    chk("lines free", 8'h03, {scl_oe_n, sda_oe_n});
    put(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    chk("err clear", 8'h00, err);
    $display("nack test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_write;
    t_read;
    t_nack;
    wrap_up;
  end
  // the tests need some 82000 cycles; a hang is cut off at 100000
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
